/* File: pkg/ssd_pkg.sv */
package ssd_pkg;

	// Register map, byte addresses on the 32-bit bus
	localparam logic [7:0]  SSD_OFS_OPWORD = 8'h00;
	localparam logic [7:0]  SSD_OFS_SRC    = 8'h04;
	localparam logic [7:0]  SSD_OFS_DST    = 8'h08;
	localparam logic [7:0]  SSD_OFS_CCR    = 8'h0c;
	localparam logic [7:0]  SSD_OFS_RESULT = 8'h10;
	localparam logic [7:0]  SSD_OFS_STATUS = 8'h14;
	localparam logic [23:0] SSD_PAGE       = 24'h000000;

	localparam logic [15:0] SSD_OPWORD_RST = 16'h0000;
	localparam logic [31:0] SSD_WORD_RST   = 32'h00000000;
	localparam logic [4:0]  SSD_CCR_RST    = 5'h00;

	// Opcode recognition fields
	localparam logic [3:0] SSD_TOP_DSUB = 4'h8;
	localparam logic [4:0] SSD_MID_DSUB = 5'h10;
	localparam logic [3:0] SSD_TOP_SCC  = 4'h5;
	localparam logic [1:0] SSD_B76_SCC  = 2'h3;
	localparam logic [3:0] SSD_TOP_SUB  = 4'h9;

	// Effective address modes and mode-7 register codes
	localparam logic [2:0] SSD_EA_DREG  = 3'h0;
	localparam logic [2:0] SSD_EA_AREG  = 3'h1;
	localparam logic [2:0] SSD_EA_IND   = 3'h2;
	localparam logic [2:0] SSD_EA_EXT   = 3'h7;
	localparam logic [2:0] SSD_X_ABSL   = 3'h1;
	localparam logic [2:0] SSD_X_IMM    = 3'h4;

	localparam logic [1:0] SSD_SZ_B = 2'h0;
	localparam logic [1:0] SSD_SZ_W = 2'h1;
	localparam logic [1:0] SSD_SZ_L = 2'h2;

	// Condition selector codes
	localparam logic [3:0] SSD_CC_T  = 4'h0;
	localparam logic [3:0] SSD_CC_F  = 4'h1;
	localparam logic [3:0] SSD_CC_HI = 4'h2;
	localparam logic [3:0] SSD_CC_LS = 4'h3;
	localparam logic [3:0] SSD_CC_CC = 4'h4;
	localparam logic [3:0] SSD_CC_CS = 4'h5;
	localparam logic [3:0] SSD_CC_NE = 4'h6;
	localparam logic [3:0] SSD_CC_EQ = 4'h7;
	localparam logic [3:0] SSD_CC_VC = 4'h8;
	localparam logic [3:0] SSD_CC_VS = 4'h9;
	localparam logic [3:0] SSD_CC_PL = 4'ha;
	localparam logic [3:0] SSD_CC_MI = 4'hb;
	localparam logic [3:0] SSD_CC_GE = 4'hc;
	localparam logic [3:0] SSD_CC_LT = 4'hd;
	localparam logic [3:0] SSD_CC_GT = 4'he;
	localparam logic [3:0] SSD_CC_LE = 4'hf;

	localparam logic [7:0] SSD_BYTE_ONES  = 8'hff;
	localparam logic [7:0] SSD_BYTE_ZEROS = 8'h00;

	// Status register field positions
	localparam int SSD_ST_CLS    = 0;
	localparam int SSD_ST_ILL    = 4;
	localparam int SSD_ST_SIZE   = 5;
	localparam int SSD_ST_EADST  = 7;
	localparam int SSD_ST_MEMOPS = 8;
	localparam int SSD_ST_PREDEC = 9;
	localparam int SSD_ST_RDFST  = 10;
	localparam int SSD_ST_MEMWR  = 11;
	localparam int SSD_ST_CTRUE  = 12;
	localparam int SSD_ST_DREG   = 13;
	localparam int SSD_ST_SREG   = 16;
	localparam int SSD_ST_EAMODE = 19;
	localparam int SSD_ST_EAREG  = 22;
	localparam int SSD_ST_COND   = 25;

	typedef enum logic [3:0] {
		SSD_CLS_NONE = 4'b0001,
		SSD_CLS_DSUB = 4'b0010,
		SSD_CLS_SCC  = 4'b0100,
		SSD_CLS_SUB  = 4'b1000
	} ssd_cls_e;

	typedef struct packed {
		logic x;
		logic n;
		logic z;
		logic v;
		logic c;
	} ssd_ccr_s;

	typedef struct packed {
		ssd_cls_e   cls;
		logic       illegal;
		logic [1:0] size;
		logic       ea_dest;
		logic       mem_ops;
		logic       areg_predec;
		logic       rd_first;
		logic       mem_wr;
		logic [2:0] dreg;
		logic [2:0] sreg;
		logic [2:0] ea_mode;
		logic [2:0] ea_reg;
		logic [3:0] cond;
	} ssd_dec_s;

endpackage

/* File: hdl/ssd_cond.sv */
`timescale 1ns/1ps
module ssd_cond (
	input  wire logic [3:0]       condition_selector,
	input  wire ssd_pkg::ssd_ccr_s flags,
	output logic                  cond_true
);
	import ssd_pkg::*;

	always_comb
	begin
		case (condition_selector)
			SSD_CC_T:  cond_true = 1'b1; // RL6 RL7
			SSD_CC_F:  cond_true = 1'b0;
			SSD_CC_HI: cond_true = ~flags.c & ~flags.z;
			SSD_CC_LS: cond_true = flags.c | flags.z;
			SSD_CC_CC: cond_true = ~flags.c;
			SSD_CC_CS: cond_true = flags.c;
			SSD_CC_NE: cond_true = ~flags.z;
			SSD_CC_EQ: cond_true = flags.z;
			SSD_CC_VC: cond_true = ~flags.v;
			SSD_CC_VS: cond_true = flags.v;
			SSD_CC_PL: cond_true = ~flags.n;
			SSD_CC_MI: cond_true = flags.n;
			SSD_CC_GE: cond_true = ~(flags.n ^ flags.v);
			SSD_CC_LT: cond_true = flags.n ^ flags.v;
			SSD_CC_GT: cond_true = ~(flags.n ^ flags.v) & ~flags.z;
			SSD_CC_LE: cond_true = (flags.n ^ flags.v) | flags.z;
			default:   cond_true = 1'b0;
		endcase
	end

endmodule

/* File: hdl/ssd_decode.sv */
`timescale 1ns/1ps
module ssd_decode (
	input  wire logic [15:0]       opword,
	output ssd_pkg::ssd_dec_s      dec
);
	import ssd_pkg::*;

	logic [2:0] mode;
	logic [2:0] reg_f;
	logic       data_alt;
	logic       mem_alt;
	logic       any_src;

	assign mode  = opword[5:3];
	assign reg_f = opword[2:0];

	always_comb
	begin
		// Mode 7 only has absolute word/long as alterable forms
		mem_alt  = (mode >= SSD_EA_IND) && ((mode != SSD_EA_EXT) || (reg_f <= SSD_X_ABSL));
		data_alt = (mode == SSD_EA_DREG) || mem_alt; // RL8
		any_src  = (mode != SSD_EA_EXT) || (reg_f <= SSD_X_IMM); // RL16
	end

	always_comb
	begin
		dec             = '0;
		dec.cls         = SSD_CLS_NONE;
		dec.ea_mode     = mode;
		dec.ea_reg      = reg_f;
		dec.dreg        = opword[11:9];
		if (opword[15:12] == SSD_TOP_DSUB && opword[8:4] == SSD_MID_DSUB) // RL1
		begin
			dec.cls         = SSD_CLS_DSUB;
			dec.size        = SSD_SZ_B;
			dec.sreg        = opword[2:0];
			dec.mem_ops     = opword[3]; // RL2
			dec.areg_predec = opword[3]; // RL3
			dec.rd_first    = opword[3];
			dec.mem_wr      = opword[3];
		end
		else if (opword[15:12] == SSD_TOP_SCC && opword[7:6] == SSD_B76_SCC) // RL5
		begin
			dec.cls      = SSD_CLS_SCC;
			dec.size     = SSD_SZ_B;
			dec.cond     = opword[11:8];
			dec.illegal  = ~data_alt; // RL8
			dec.ea_dest  = 1'b1;
			dec.rd_first = data_alt && (mode != SSD_EA_DREG); // RL9
			dec.mem_wr   = data_alt && (mode != SSD_EA_DREG);
		end
		else if (opword[15:12] == SSD_TOP_SUB) // RL14
		begin
			dec.cls     = SSD_CLS_SUB;
			dec.size    = opword[7:6]; // RL15
			dec.ea_dest = opword[8];
			dec.sreg    = opword[2:0];
			if (opword[7:6] == 2'h3)
				dec.illegal = 1'b1;
			else if (opword[8])
			begin
				dec.illegal  = ~mem_alt;
				dec.rd_first = mem_alt;
				dec.mem_wr   = mem_alt; // RL15
			end
			else
			begin
				dec.illegal  = ~any_src || (opword[7:6] == SSD_SZ_B && mode == SSD_EA_AREG); // RL16 RL17
				dec.rd_first = any_src && (mode >= SSD_EA_IND) &&
					!(mode == SSD_EA_EXT && reg_f == SSD_X_IMM);
			end
		end
	end

endmodule

/* File: hdl/ssd_top.sv */
// What this block does
// RL1 - Decimal subtract: top nibble 1000, bits 8..4 10000; dst, mode, src fields.
// RL2 - Mode bit 0 uses data registers; 1 uses memory operands and memory result.
// RL3 - Memory mode registers are address registers with predecrement; else data registers.
// RL4 - Set-byte writes all ones if condition true, all zeros if false.
// RL5 - Set-byte: top nibble 0101, bits 7,6 set; condition 11..8, address 5..0.
// RL6 - Sixteen condition tests from true/false through less-or-equal.
// RL7 - Condition codes 0000 to 1111 in the fixed documented order.
// RL8 - Set-byte destination only data-alterable; address register, immediate, PC-relative illegal.
// RL9 - Set-byte reads a memory destination before writing it.
// RL10 - Set-byte leaves all flags unchanged; byte negate later gives 1 or 0.
// RL11 - Binary subtract: destination minus source, byte, word or long by opmode.
// RL12 - Carry set on borrow, extend copies carry.
// RL13 - Negative, zero, overflow reflect the result; cleared when absent.
// RL14 - Binary subtract: top nibble 1001, register 11..9, opmode 8..6, address 5..0.
// RL15 - Opmodes 0xx subtract address operand from register; 1xx write to memory.
// RL16 - Source address accepts every mode including immediate and PC-relative.
// RL17 - Byte subtract rejects address register direct as source.
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module ssd_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	import ssd_pkg::*;

	// Bus phase tracking
	logic        dp_act_q;
	logic        dp_act_d;
	logic        dp_wr_q;
	logic        dp_wr_d;
	logic [7:0]  dp_addr_q;
	logic [7:0]  dp_addr_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;

	// Software-visible state
	logic [15:0] opword_q;
	logic [15:0] opword_d;
	logic [31:0] src_q;
	logic [31:0] src_d;
	logic [31:0] dst_q;
	logic [31:0] dst_d;
	logic [31:0] result_q;
	logic [31:0] result_d;
	logic [31:0] status_q;
	logic [31:0] status_d;
	ssd_ccr_s    ccr_q;
	ssd_ccr_s    ccr_d;

	logic        addr_ph;
	logic        wr_now;
	logic        exec;
	logic [15:0] op_in;
	ssd_dec_s    dec;
	logic        cond_true;
	logic        page_hit;
	logic        wr_src;
	logic        wr_dst;
	logic        wr_ccr;
	logic [7:0]  scc_byte;
	logic [31:0] status_new;
	ssd_ccr_s    sub_flags;

	// Bus response state
	logic        hreadyout_q;
	logic        hreadyout_d;
	logic        hresp_q;
	logic        hresp_d;

	logic [8:0]  diff_b;
	logic [16:0] diff_w;
	logic [32:0] diff_l;
	logic [31:0] sub_res;
	logic        borrow;
	logic        r_msb;
	logic        s_msb;
	logic        d_msb;
	logic        r_zero;

	// Off-page transfers are answered but never reach a register
	assign page_hit = (haddr[31:8] == SSD_PAGE);
	assign addr_ph  = hsel && hready && htrans[1] && page_hit;
	assign wr_now   = dp_act_q && dp_wr_q;
	assign exec     = wr_now && (dp_addr_q == SSD_OFS_OPWORD);
	assign wr_src   = wr_now && (dp_addr_q == SSD_OFS_SRC);
	assign wr_dst   = wr_now && (dp_addr_q == SSD_OFS_DST);
	assign wr_ccr   = wr_now && (dp_addr_q == SSD_OFS_CCR);
	// The test uses the flags as they stood before this instruction
	assign scc_byte = cond_true ? SSD_BYTE_ONES : SSD_BYTE_ZEROS; // RL4
	// Decoding the write data directly lets the result be ready when the write completes
	assign op_in   = exec ? hwdata[15:0] : opword_q;

	ssd_decode u_decode (
		.opword (op_in),
		.dec    (dec)
	);

	ssd_cond u_cond (
		.condition_selector (dec.cond),
		.flags              (ccr_q),
		.cond_true          (cond_true)
	);

	// Destination minus source at each size; the opmode picks one
	always_comb
	begin
		diff_b = {1'b0, dst_q[7:0]} - {1'b0, src_q[7:0]}; // RL11
		diff_w = {1'b0, dst_q[15:0]} - {1'b0, src_q[15:0]};
		diff_l = {1'b0, dst_q} - {1'b0, src_q};
		case (dec.size)
			SSD_SZ_B:
			begin
				sub_res = {dst_q[31:8], diff_b[7:0]};
				borrow  = diff_b[8];
				r_msb   = diff_b[7];
				s_msb   = src_q[7];
				d_msb   = dst_q[7];
				r_zero  = (diff_b[7:0] == 8'h00);
			end
			SSD_SZ_W:
			begin
				sub_res = {dst_q[31:16], diff_w[15:0]};
				borrow  = diff_w[16];
				r_msb   = diff_w[15];
				s_msb   = src_q[15];
				d_msb   = dst_q[15];
				r_zero  = (diff_w[15:0] == 16'h0000);
			end
			default:
			begin
				sub_res = diff_l[31:0];
				borrow  = diff_l[32];
				r_msb   = diff_l[31];
				s_msb   = src_q[31];
				d_msb   = dst_q[31];
				r_zero  = (diff_l[31:0] == 32'h00000000);
			end
		endcase
	end

	// Flags of the binary subtract at the operation size
	always_comb
	begin
		sub_flags.x = borrow; // RL12
		sub_flags.n = r_msb; // RL13
		sub_flags.z = r_zero; // RL13
		sub_flags.v = (s_msb ^ d_msb) & (r_msb ^ d_msb); // RL13
		sub_flags.c = borrow; // RL12
	end

	// Bus slave: zero wait states, read data loaded at the address phase
	always_comb
	begin
		dp_act_d  = addr_ph;
		dp_wr_d   = addr_ph && hwrite;
		dp_addr_d = addr_ph ? haddr[7:0] : dp_addr_q;
	end

	// Response group: every bus output is a flop, ready in every data phase
	always_comb
	begin
		hreadyout_d = 1'b1;
		hresp_d     = 1'b0;
		hrdata_d    = 32'h00000000;
		if (addr_ph && !hwrite)
		begin
			case (haddr[7:0])
				SSD_OFS_OPWORD: hrdata_d = {16'h0000, opword_q};
				SSD_OFS_SRC:    hrdata_d = src_q;
				SSD_OFS_DST:    hrdata_d = dst_q;
				SSD_OFS_CCR:    hrdata_d = {27'h0000000, ccr_q};
				SSD_OFS_RESULT: hrdata_d = result_q;
				SSD_OFS_STATUS: hrdata_d = status_q;
				default:        hrdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_act_q  <= 1'b0;
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
		end
		else
		begin
			dp_act_q  <= dp_act_d;
			dp_wr_q   <= dp_wr_d;
			dp_addr_q <= dp_addr_d;
		end
	end

	// Ready stays low while reset holds, so no transfer is taken then
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout_q <= 1'b0;
			hresp_q     <= 1'b0;
			hrdata_q    <= SSD_WORD_RST;
		end
		else
		begin
			hreadyout_q <= hreadyout_d;
			hresp_q     <= hresp_d;
			hrdata_q    <= hrdata_d;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp     = hresp_q;
	assign hrdata    = hrdata_q;

	// Status snapshot of the word being executed
	always_comb
	begin
		status_new                     = 32'h00000000;
		status_new[SSD_ST_CLS +: 4]    = dec.cls;
		status_new[SSD_ST_ILL]         = dec.illegal;
		status_new[SSD_ST_SIZE +: 2]   = dec.size;
		status_new[SSD_ST_EADST]       = dec.ea_dest;
		status_new[SSD_ST_MEMOPS]      = dec.mem_ops; // RL2
		status_new[SSD_ST_PREDEC]      = dec.areg_predec; // RL3
		status_new[SSD_ST_RDFST]       = dec.rd_first; // RL9
		status_new[SSD_ST_MEMWR]       = dec.mem_wr;
		status_new[SSD_ST_CTRUE]       = cond_true;
		status_new[SSD_ST_DREG +: 3]   = dec.dreg;
		status_new[SSD_ST_SREG +: 3]   = dec.sreg;
		status_new[SSD_ST_EAMODE +: 3] = dec.ea_mode;
		status_new[SSD_ST_EAREG +: 3]  = dec.ea_reg;
		status_new[SSD_ST_COND +: 4]   = dec.cond;
	end

	// Register writes and instruction execution
	always_comb
	begin
		opword_d = opword_q;
		src_d    = src_q;
		dst_d    = dst_q;
		ccr_d    = ccr_q;
		result_d = result_q;
		status_d = status_q;
		if (wr_src)
			src_d = hwdata;
		if (wr_dst)
			dst_d = hwdata;
		if (wr_ccr)
			ccr_d = hwdata[4:0];
		if (exec)
		begin
			opword_d = hwdata[15:0];
			status_d = status_new;
			// Illegal forms change neither the result nor the flags
			if (!dec.illegal)
			begin
				case (dec.cls)
					SSD_CLS_SCC:
						// Flags untouched
						result_d = {dst_q[31:8], scc_byte}; // RL4 RL10
					SSD_CLS_SUB:
					begin
						result_d = sub_res; // RL11
						ccr_d    = sub_flags; // RL12 RL13
					end
					// Decimal arithmetic is outside this block; operand routing only
					SSD_CLS_DSUB: result_d = dst_q;
					SSD_CLS_NONE: result_d = result_q;
					default:      result_d = result_q;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			opword_q <= SSD_OPWORD_RST;
			src_q    <= SSD_WORD_RST;
			dst_q    <= SSD_WORD_RST;
			ccr_q    <= SSD_CCR_RST;
			result_q <= SSD_WORD_RST;
			status_q <= SSD_WORD_RST;
		end
		else
		begin
			opword_q <= opword_d;
			src_q    <= src_d;
			dst_q    <= dst_d;
			ccr_q    <= ccr_d;
			result_q <= result_d;
			status_q <= status_d;
		end
	end

endmodule

/* File: verif/ssd_ahb_bfm.sv */
`timescale 1ns/1ps
module ssd_ahb_bfm (
	input  wire logic        hclk,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// No wait count is assumed; only the bench timeout ends a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk iff hready);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk iff hready);
		q = hrdata;
		hsel <= 1'b0;
		// Released data toggles so a stale value is never mistaken for a fresh one
		hwdata <= ~d;
	endtask
endmodule

/* File: verif/ssd_top_assertions.sv */
`timescale 1ns/1ps
module ssd_top_chk (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [31:0] hrdata
);
	import ssd_pkg::*;
	logic        acc;
	logic        wop_q, wop_d, rst_q, rst_d;
	logic [15:0] op_q, op_d;
	logic        sc, su, ds;
	assign acc = hsel && hready && htrans[1] && haddr[31:8] == SSD_PAGE;
	assign sc = op_q[15:12] == SSD_TOP_SCC && op_q[7:6] == SSD_B76_SCC;
	assign su = op_q[15:12] == SSD_TOP_SUB;
	assign ds = op_q[15:12] == SSD_TOP_DSUB && op_q[8:4] == SSD_MID_DSUB;
	always_comb
	begin
		wop_d = acc && hwrite && haddr[7:0] == SSD_OFS_OPWORD;
		rst_d = acc && !hwrite && haddr[7:0] == SSD_OFS_STATUS;
		op_d = wop_q ? hwdata[15:0] : op_q;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wop_q <= 1'b0;
			rst_q <= 1'b0;
			op_q <= 16'h0;
		end
		else
		begin
			wop_q <= wop_d;
			rst_q <= rst_d;
			op_q <= op_d;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_dsub_fields: assert property (rst_q && ds |-> hrdata[3:0] == SSD_CLS_DSUB
		&& hrdata[15:13] == op_q[11:9] && hrdata[18:16] == op_q[2:0]) else $error("decimal subtract fields wrong");
	a_dsub_mode: assert property (rst_q && ds |-> hrdata[9:8] == {2{op_q[3]}})
		else $error("decimal subtract mode wrong");
	a_scc_legal: assert property (rst_q && sc && op_q[5:3] != SSD_EA_AREG && op_q[5:0] < 6'h3a
		|-> hrdata[4:0] == {1'b0, SSD_CLS_SCC} && hrdata[28:25] == op_q[11:8]) else $error("set byte decode wrong");
	a_scc_bad_ea: assert property (rst_q && sc && (op_q[5:3] == SSD_EA_AREG || op_q[5:0] > 6'h39) |-> hrdata[4])
		else $error("set byte bad address accepted");
	a_scc_rmw: assert property (rst_q && sc && op_q[5:3] >= SSD_EA_IND && op_q[5:3] != SSD_EA_EXT
		|-> hrdata[11:10] == 2'h3) else $error("set byte memory read missing");
	a_sub_size: assert property (rst_q && su && !op_q[8] && op_q[7:6] != 2'h3 && op_q[5:3] == SSD_EA_DREG
		|-> hrdata[7:0] == {1'b0, op_q[7:6], 1'b0, SSD_CLS_SUB}) else $error("subtract size wrong");
	a_sub_mem_dst: assert property (rst_q && su && op_q[8] && op_q[7:6] != 2'h3 && op_q[5:3] >= SSD_EA_IND
		&& op_q[5:3] != SSD_EA_EXT |-> hrdata[7] && hrdata[11]) else $error("subtract memory result wrong");
	a_sub_byte_an: assert property (rst_q && su && op_q[8:6] == 3'h0 && op_q[5:3] == SSD_EA_AREG |-> hrdata[4])
		else $error("byte subtract address source accepted");
	a_sub_all_src: assert property (rst_q && su && op_q[8:6] == 3'h1 && op_q[5:0] == 6'h3c |-> !hrdata[4])
		else $error("subtract immediate source refused");
endmodule

bind ssd_top ssd_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata));

/* File: verif/subtract_setcond_decode_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module subtract_setcond_decode_tb;
	import ssd_pkg::*;
	typedef struct packed {
		logic [15:0] op;
		logic [31:0] src;
		logic [31:0] dst;
		logic [4:0]  cin;
		logic [31:0] res;
		logic [4:0]  cout;
	} ssd_row_s;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel, hwrite, hready, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q, st, keep;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [4:0]  fl [5] = '{5'h00, 5'h0f, 5'h1a, 5'h05, 5'h12};
	ssd_row_s    rows [7] = '{'{16'h9001, 32'h1, 32'h12345600, 5'h00, 32'h123456ff, 5'h19},
		'{16'h9041, 32'h1, 32'habcd8000, 5'h00, 32'habcd7fff, 5'h02},
		'{16'h9081, 32'h5, 32'h5, 5'h1f, 32'h0, 5'h04},
		'{16'h907c, 32'h10, 32'h8, 5'h00, 32'hfff8, 5'h19},
		'{16'h9190, 32'h1, 32'h80000000, 5'h00, 32'h7fffffff, 5'h02},
		'{16'h90ba, 32'h7fffffff, 32'hffffffff, 5'h00, 32'h80000000, 5'h08},
		'{16'h830a, 32'h11, 32'h99, 5'h1f, 32'h99, 5'h1f}};
	always #2.5 hclk = ~hclk;
	ssd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
	ssd_ahb_bfm bfm (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata));

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bfm.xfer(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
		`CHK("okay response", 1'b0, hresp)
	endtask

	task automatic run(input logic [15:0] op, input logic [31:0] s, input logic [31:0] d, input logic [4:0] c);
		bfm.xfer(1'b1, SSD_OFS_SRC, s, q);
		bfm.xfer(1'b1, SSD_OFS_DST, d, q);
		bfm.xfer(1'b1, SSD_OFS_CCR, {27'h0, c}, q);
		bfm.xfer(1'b1, SSD_OFS_OPWORD, {16'h0, op}, q);
		bfm.xfer(1'b0, SSD_OFS_STATUS, 32'h0, st);
	endtask

	// Codes pair up: bit 0 inverts the test picked by bits 3..1
	function automatic logic ctest(input logic [3:0] cc, input logic [4:0] f);
		logic t;
		case (cc[3:1])
			3'h0: t = 1'b1;
			3'h1: t = !f[0] && !f[2];
			3'h2: t = !f[0];
			3'h3: t = !f[2];
			3'h4: t = !f[1];
			3'h5: t = !f[3];
			3'h6: t = f[3] == f[1];
			default: t = f[3] == f[1] && !f[2];
		endcase
		return t ^ cc[0];
	endfunction

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			n_mismatch++;
			test_done;
		end
	end

	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(SSD_OFS_RESULT, 32'h0, "reset result");
		rd_chk(SSD_OFS_STATUS, 32'h0, "reset status");
		foreach (rows[i])
		begin
			run(rows[i].op, rows[i].src, rows[i].dst, rows[i].cin);
			rd_chk(SSD_OFS_RESULT, rows[i].res, "result");
			rd_chk(SSD_OFS_CCR, {27'h0, rows[i].cout}, "flags");
		end
		for (int cc = 0; cc < 16; cc++)
			foreach (fl[j])
			begin
				run({4'h5, 4'(cc), 2'h3, 6'h00}, 32'h0, 32'h12345677, fl[j]);
				rd_chk(SSD_OFS_RESULT, {24'h123456, ctest(4'(cc), fl[j]) ? SSD_BYTE_ONES : SSD_BYTE_ZEROS}, "set");
				rd_chk(SSD_OFS_CCR, {27'h0, fl[j]}, "set flags");
			end
		bfm.xfer(1'b0, SSD_OFS_RESULT, 32'h0, keep);
		run(16'h9009, 32'h1, 32'h5, 5'h00);
		`CHK("byte an flag", 1'b1, st[4])
		rd_chk(SSD_OFS_RESULT, keep, "byte an result");
		run(16'h50c8, 32'h0, 32'h0, 5'h00);
		`CHK("set an flag", 1'b1, st[4])
		run(16'h50fa, 32'h0, 32'h0, 5'h00);
		`CHK("set pc flag", 1'b1, st[4])
		run(16'h50d0, 32'h0, 32'h0, 5'h00);
		`CHK("set rmw", 2'h3, st[11:10])
		run(16'h8301, 32'h0, 32'h0, 5'h00);
		`CHK("dsub reg", 6'h02, {st[9:8], st[3:0]})
		bfm.xfer(1'b1, SSD_OFS_RESULT, 32'hdeadbeef, q);
		rd_chk(SSD_OFS_RESULT, 32'h0, "result read only");
		rd_chk(8'h20, 32'h0, "unmapped");
		bfm.xfer(1'b1, SSD_OFS_CCR, 32'h1f, q);
		rd_chk(SSD_OFS_CCR, 32'h1f, "ccr written");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(SSD_OFS_CCR, 32'h0, "reset again");
		test_done;
	end
endmodule
